/* File: src/ble_instr_unit.sv */
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module ble_instr_unit (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic [15:0] OUT_TERM
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [15:0] mem_reg [0:ble_pkg::MEM_WORDS-1];
   logic [31:0] ctrl_reg;
   logic [31:0] oper_reg;
   logic [31:0] madr_reg;
   logic [7:0] flag_reg;
   logic [15:0] prev_reg;
   logic [15:0] term_reg;
   logic ack_reg;
   logic [31:0] dat_reg;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic bus_do;
   logic wr_do;
   logic exec;
   assign bus_do = WB_CYC_I & WB_STB_I & ack_reg;
   assign wr_do = bus_do & WB_WE_I;
   assign exec = wr_do & (WB_ADR_I == ble_pkg::ADR_CTRL);

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ----------------------------------------
   // instruction fields from the bus word, operand fields from oper_reg
   // ----------------------------------------
   ble_pkg::ble_op_t op;
   logic cond;
   logic rst_cond;
   logic sect;
   logic imm;
   logic [3:0] inst;
   logic [4:0] w0;
   logic [4:0] w1;
   logic [7:0] start;
   logic [5:0] count;
   logic [3:0] bitn;
   assign op = ble_pkg::ble_op_t'(WB_DAT_I[ble_pkg::OP_LSB +: ble_pkg::OP_W]);
   assign cond = WB_DAT_I[ble_pkg::COND_BIT];
   assign rst_cond = WB_DAT_I[ble_pkg::RSTC_BIT];
   assign sect = WB_DAT_I[ble_pkg::SECT_BIT];
   assign imm = WB_DAT_I[ble_pkg::IMM_BIT];
   assign inst = WB_DAT_I[ble_pkg::INST_LSB +: ble_pkg::INST_W];
   assign w0 = oper_reg[ble_pkg::WORD_LSB +: ble_pkg::WORD_W];
   assign w1 = w0 + 5'h01;
   assign start = oper_reg[ble_pkg::START_LSB +: ble_pkg::START_W];
   assign count = oper_reg[ble_pkg::COUNT_LSB +: ble_pkg::COUNT_W];
   assign bitn = start[3:0];

   // ----------------------------------------
   // execution
   // ----------------------------------------
   logic [15:0] cur0;
   logic [15:0] nw0;
   logic [15:0] nw1;
   logic wr0;
   logic wr1;
   logic prev_wr;
   logic err_wr;
   logic err_val;
   logic term_wr;
   logic [15:0] onehot;
   logic [63:0] run;
   logic tc_word;
   assign cur0 = mem_reg[w0];
   assign onehot = 16'h0001 << bitn;
   assign tc_word = (w0 >= ble_pkg::TC_FIRST);

   always_comb begin
      nw0 = cur0;
      nw1 = mem_reg[w1];
      wr0 = 1'b0;
      wr1 = 1'b0;
      prev_wr = 1'b0;
      err_wr = 1'b0;
      err_val = 1'b0;
      term_wr = 1'b0;
      run = ((64'h0000_0000_0000_0001 << count) - 64'h0000_0000_0000_0001) << start[3:0];
      case (op)
         ble_pkg::OP_KEEP: begin
            // a disabled section leaves the latch as it is
            if (sect) begin
               wr0 = 1'b1;
               if (rst_cond) begin
                  nw0 = cur0 & ~onehot;
               end else if (cond) begin
                  nw0 = cur0 | onehot;
               end
               term_wr = imm;
            end
         end
         ble_pkg::OP_RISE: begin
            if (sect) begin
               wr0 = 1'b1;
               prev_wr = 1'b1;
               if (cond & ~prev_reg[inst]) begin
                  nw0 = cur0 | onehot;
               end else begin
                  nw0 = cur0 & ~onehot;
               end
               term_wr = imm;
            end
         end
         ble_pkg::OP_FALL: begin
            if (sect) begin
               wr0 = 1'b1;
               prev_wr = 1'b1;
               if (~cond & prev_reg[inst]) begin
                  nw0 = cur0 | onehot;
               end else begin
                  nw0 = cur0 & ~onehot;
               end
               term_wr = imm;
            end
         end
         ble_pkg::OP_SET: begin
            if (sect & cond & ~tc_word) begin
               wr0 = 1'b1;
               nw0 = cur0 | onehot;
               term_wr = imm;
            end
         end
         ble_pkg::OP_CLR: begin
            if (sect & cond & ~tc_word) begin
               wr0 = 1'b1;
               nw0 = cur0 & ~onehot;
               term_wr = imm;
            end
         end
         ble_pkg::OP_MSET, ble_pkg::OP_MCLR: begin
            if (sect & cond) begin
               err_wr = 1'b1;
               err_val = (start > ble_pkg::MAX_BIT);
               if (!err_val) begin
                  wr0 = 1'b1;
                  wr1 = (w1 != ble_pkg::OUT_WORD);
                  if (op == ble_pkg::OP_MSET) begin
                     nw0 = cur0 | run[15:0];
                     nw1 = mem_reg[w1] | run[31:16];
                  end else begin
                     nw0 = cur0 & ~run[15:0];
                     nw1 = mem_reg[w1] & ~run[31:16];
                  end
               end
            end
         end
         ble_pkg::OP_REFR: begin
            // word 0 goes out whole in the terminal block; no memory write
            wr0 = 1'b0;
         end
         default: begin
            nw0 = cur0;
         end
      endcase
   end

   // ----------------------------------------
   // bit memory: retained words skip reset
   // ----------------------------------------
   logic mdat_wr;
   logic [31:0] mdat_mrg;
   assign mdat_wr = wr_do & (WB_ADR_I == ble_pkg::ADR_MDAT);
   assign mdat_mrg = merge({16'h0000, mem_reg[madr_reg[4:0]]}, WB_DAT_I, WB_SEL_I);

   for (genvar g = 0; g < ble_pkg::MEM_WORDS; g++) begin : g_word
      // the retained area keeps its contents through reset
      localparam bit RETAIN = (g >= int'(ble_pkg::RET_FIRST)) && (g <= int'(ble_pkg::RET_LAST));
      always_ff @(posedge CLK_SYS) begin
         if (!RST_N) begin
            if (!RETAIN) begin
               mem_reg[g] <= ble_pkg::WORD_RST;
            end
         end else if (mdat_wr && madr_reg[4:0] == 5'(g)) begin
            mem_reg[g] <= mdat_mrg[15:0];
         end else if (exec && wr0 && w0 == 5'(g)) begin
            // written at once so the next instruction reads the result
            mem_reg[g] <= nw0;
         end else if (exec && wr1 && w1 == 5'(g)) begin
            mem_reg[g] <= nw1;
         end
      end
   end

   // ----------------------------------------
   // per-instance previous condition
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         prev_reg <= 16'h0000;
      end else if (exec && prev_wr) begin
         prev_reg[inst] <= cond;
      end
   end

   // ----------------------------------------
   // output terminals
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         term_reg <= 16'h0000;
      end else if (exec && op == ble_pkg::OP_REFR) begin
         term_reg <= mem_reg[ble_pkg::OUT_WORD];
      end else if (exec && term_wr && w0 == ble_pkg::OUT_WORD) begin
         term_reg <= nw0;
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ctrl_reg <= ble_pkg::CTRL_RST;
      end else if (wr_do && WB_ADR_I == ble_pkg::ADR_CTRL) begin
         ctrl_reg <= WB_DAT_I;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         oper_reg <= ble_pkg::OPER_RST;
      end else if (wr_do && WB_ADR_I == ble_pkg::ADR_OPER) begin
         oper_reg <= merge(oper_reg, WB_DAT_I, WB_SEL_I);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         madr_reg <= ble_pkg::OPER_RST;
      end else if (wr_do && WB_ADR_I == ble_pkg::ADR_MADR) begin
         madr_reg <= merge(madr_reg, WB_DAT_I, WB_SEL_I) & 32'h0000_001F;
      end
   end

   // ----------------------------------------
   // condition flags
   // ----------------------------------------
   // of the instructions only the multi-bit group touches the error flag; a bus write to the flag register also does
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         flag_reg <= ble_pkg::FLAG_RST;
      end else if (exec && err_wr) begin
         flag_reg[ble_pkg::ERR_BIT] <= err_val;
      end else if (wr_do && WB_ADR_I == ble_pkg::ADR_FLAG && WB_SEL_I[0]) begin
         flag_reg <= WB_DAT_I[ble_pkg::FLAG_W-1:0];
      end
   end

   // ----------------------------------------
   // bus answer: ack one cycle after the request
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
      end
   end

   // ----------------------------------------
   // read data, latched at the request edge
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         dat_reg <= 32'h0000_0000;
      end else if (WB_CYC_I & WB_STB_I & ~ack_reg) begin
         case (WB_ADR_I)
            ble_pkg::ADR_CTRL: dat_reg <= ctrl_reg;
            ble_pkg::ADR_OPER: dat_reg <= oper_reg;
            ble_pkg::ADR_FLAG: dat_reg <= {24'h00_0000, flag_reg};
            ble_pkg::ADR_MADR: dat_reg <= madr_reg;
            ble_pkg::ADR_MDAT: dat_reg <= {16'h0000, mem_reg[madr_reg[4:0]]};
            ble_pkg::ADR_EDGE: dat_reg <= {16'h0000, prev_reg};
            default: dat_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // ports
   // ----------------------------------------
   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = dat_reg;
   assign OUT_TERM = term_reg;
endmodule : ble_instr_unit

/* File: src/ble_pkg.sv */
package ble_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_OPER = 8'h04;
   localparam logic [7:0] ADR_FLAG = 8'h08;
   localparam logic [7:0] ADR_MADR = 8'h0C;
   localparam logic [7:0] ADR_MDAT = 8'h10;
   localparam logic [7:0] ADR_EDGE = 8'h14;
   // ----------------------------------------
   // control word fields
   // ----------------------------------------
   localparam int OP_LSB = 0;
   localparam int OP_W = 12;
   localparam int COND_BIT = 12;
   localparam int RSTC_BIT = 13;
   localparam int SECT_BIT = 14;
   localparam int IMM_BIT = 15;
   localparam int INST_LSB = 16;
   localparam int INST_W = 4;
   // ----------------------------------------
   // operand word and flag register fields
   // ----------------------------------------
   localparam int WORD_LSB = 0;
   localparam int WORD_W = 5;
   localparam int START_LSB = 8;
   localparam int START_W = 8;
   localparam int COUNT_LSB = 16;
   localparam int COUNT_W = 6;
   localparam int ERR_BIT = 0;
   localparam int FLAG_W = 8;
   localparam logic [7:0] MAX_BIT = 8'h0F;
   // ----------------------------------------
   // bit memory layout
   // ----------------------------------------
   localparam int MEM_WORDS = 32;
   localparam logic [4:0] OUT_WORD = 5'h00;
   localparam logic [4:0] RET_FIRST = 5'h10;
   localparam logic [4:0] RET_LAST = 5'h17;
   localparam logic [4:0] TC_FIRST = 5'h1C;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] OPER_RST = 32'h0000_0000;
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // ----------------------------------------
   // instruction codes
   // ----------------------------------------
   typedef enum logic [11:0] {
      OP_KEEP = 12'h011,
      OP_RISE = 12'h013,
      OP_FALL = 12'h014,
      OP_SET = 12'h0F1,
      OP_CLR = 12'h0F2,
      OP_REFR = 12'h0FF,
      OP_MSET = 12'h530,
      OP_MCLR = 12'h531
   } ble_op_t;
endpackage : ble_pkg

/* File: tb/ble_instr_unit_properties.sv */
`timescale 1ns/1ps
module ble_chk (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic [15:0] OUT_TERM
);
   // ----------------------------------------
   // bus decode and operand shadow
   // ----------------------------------------
   logic [31:0] oper_reg;
   wire req = WB_CYC_I && WB_STB_I;
   wire cw = req && WB_WE_I && WB_ACK_O && WB_ADR_I == ble_pkg::ADR_CTRL;
   wire [11:0] opc = WB_DAT_I[11:0];
   wire cond = WB_DAT_I[ble_pkg::COND_BIT];
   wire on0 = cw && WB_DAT_I[ble_pkg::SECT_BIT] && WB_DAT_I[ble_pkg::IMM_BIT] && oper_reg[4:0] == 5'h00;
   wire [3:0] bn = oper_reg[11:8];
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         oper_reg <= 32'h0000_0000;
      end else if (req && WB_WE_I && WB_ACK_O && WB_ADR_I == ble_pkg::ADR_OPER) begin
         for (int i = 0; i < 4; i++) begin
            if (WB_SEL_I[i]) oper_reg[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
         end
      end
   end
   sequence s_req;
      req && !WB_ACK_O;
   endsequence
   sequence s_ans;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   AST_ACK_LAT: assert property (s_req |=> s_ans)
      else $error("ack is not a single pulse one cycle after request");
   AST_NO_ACK: assert property (!req |=> !WB_ACK_O)
      else $error("ack without request");
   AST_DAT_HOLD: assert property (!req |=> $stable(WB_DAT_O))
      else $error("read data moved while idle");
   AST_RST_VAL: assert property ($rose(RST_N) |-> OUT_TERM == 16'h0000 && !WB_ACK_O)
      else $error("outputs not cleared by reset");
   AST_OUT_CAUSE: assert property ($changed(OUT_TERM) |-> $past(cw))
      else $error("terminals changed without an instruction");
   AST_PLAIN_HOLD: assert property (cw && !WB_DAT_I[ble_pkg::IMM_BIT]
      && opc != ble_pkg::OP_REFR |=> $stable(OUT_TERM))
      else $error("terminals refreshed without immediate request");
   AST_SECT_OFF: assert property (cw && !WB_DAT_I[ble_pkg::SECT_BIT]
      && opc != ble_pkg::OP_REFR |=> $stable(OUT_TERM))
      else $error("disabled section changed terminals");
   AST_IMM_SET: assert property (on0 && cond && opc == ble_pkg::OP_SET |=> OUT_TERM[bn])
      else $error("immediate set did not drive terminal");
   AST_IMM_CLR: assert property (on0 && cond && opc == ble_pkg::OP_CLR |=> !OUT_TERM[bn])
      else $error("immediate clear did not drive terminal");
   AST_KEEP_RST: assert property (on0 && WB_DAT_I[ble_pkg::RSTC_BIT]
      && opc == ble_pkg::OP_KEEP |=> !OUT_TERM[bn])
      else $error("latch reset did not win");
   AST_PULSE_OFF: assert property (on0 && ((opc == ble_pkg::OP_RISE && !cond)
      || (opc == ble_pkg::OP_FALL && cond)) |=> !OUT_TERM[bn])
      else $error("pulse terminal not off");
endmodule : ble_chk
bind ble_instr_unit ble_chk u_ble_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .OUT_TERM(OUT_TERM));

/* File: tb/ble_prog.sv */
`timescale 1ns/1ps
module ble_prog (
   input wire logic [11:0] opc,
   input wire logic set_c,
   input wire logic rst_c,
   input wire logic sect,
   input wire logic imm,
   input wire logic [3:0] inst,
   output logic [31:0] ctrl
);
   // reset condition, then set condition, then the instruction itself
   assign ctrl = {12'h000, inst, imm, sect, rst_c, set_c, opc};
endmodule : ble_prog

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ps = 0, pr = 0, pe = 0, pi = 0;
   logic [7:0] adr = 8'h00, flg = 8'h00;
   logic [31:0] dat = 32'h0000_0000, rd_o, ctrl;
   logic [15:0] ot = 16'h0000, hist = 16'h0000, term, m [32];
   logic [11:0] popc = 12'h000;
   logic [3:0] pn = 4'h0, sel = 4'hF;
   logic [31:0] eq [$];
   logic ack;
   int failures = 0, checks_done = 0, cyc_n = 0;
   logic [11:0] ops [7] = '{ble_pkg::OP_KEEP, ble_pkg::OP_RISE, ble_pkg::OP_FALL,
      ble_pkg::OP_SET, ble_pkg::OP_CLR, ble_pkg::OP_MSET, ble_pkg::OP_MCLR};
   logic [4:0] ws [4] = '{5'h00, 5'h01, 5'h10, 5'h1C};
   initial begin
      forever #50 clk = ~clk;
   end
   ble_instr_unit u_ble_instr_unit (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
      .WB_DAT_O(rd_o), .WB_ACK_O(ack), .OUT_TERM(term));
   ble_prog u_ble_prog (.opc(popc), .set_c(ps), .rst_c(pr), .sect(pe), .imm(pi), .inst(pn),
      .ctrl(ctrl));
   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      eq.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask : rd
   task automatic rdw(input logic [4:0] w);
      wb(1'b1, ble_pkg::ADR_MADR, {27'h0, w});
      rd(ble_pkg::ADR_MDAT, {16'h0000, m[w]});
   endtask : rdw
   always @(posedge clk) begin
      if (ack === 1'b1 && cyc && !we && eq.size() != 0) begin
         chk("read data", eq.pop_front(), rd_o);
      end
      cyc_n++;
      if (cyc_n > 20000) begin
         failures++;
         end_sim();
      end
   end
   // ----------------------------------------
   // reference model of one instruction
   // ----------------------------------------
   task automatic apply(input logic [31:0] c, input logic [31:0] o);
      logic [4:0] w;
      logic [3:0] b;
      logic cn;
      w = o[4:0];
      b = o[11:8];
      cn = c[12];
      if (c[14] || c[11:0] == ble_pkg::OP_REFR) begin
         case (c[11:0])
            ble_pkg::OP_KEEP: if (c[13]) m[w][b] = 1'b0; else if (cn) m[w][b] = 1'b1;
            ble_pkg::OP_RISE: m[w][b] = cn & ~hist[c[19:16]];
            ble_pkg::OP_FALL: m[w][b] = ~cn & hist[c[19:16]];
            ble_pkg::OP_SET: if (cn && w < ble_pkg::TC_FIRST) m[w][b] = 1'b1;
            ble_pkg::OP_CLR: if (cn && w < ble_pkg::TC_FIRST) m[w][b] = 1'b0;
            ble_pkg::OP_REFR: ot = m[0];
            default: if (cn) begin
               flg[0] = o[15:8] > ble_pkg::MAX_BIT;
               for (int p = o[15:8]; p < o[15:8] + o[21:16] && !flg[0]; p++) begin
                  if (p < 16) m[w][p] = ~c[0];
                  else if (p < 32 && w != 5'h1F) m[w + 5'h01][p - 16] = ~c[0];
               end
            end
         endcase
         if (c[11:0] == ble_pkg::OP_RISE || c[11:0] == ble_pkg::OP_FALL) hist[c[19:16]] = cn;
         if (c[15] && w == 5'h00 && c[11:8] == 4'h0 && (cn || c[7:4] != 4'hF)) ot = m[0];
      end
   endtask : apply
   task automatic run(input logic [31:0] o);
      wb(1'b1, ble_pkg::ADR_OPER, o);
      wb(1'b1, ble_pkg::ADR_CTRL, ctrl);
      apply(ctrl, o);
      chk("terminals", {16'h0000, ot}, {16'h0000, term});
   endtask : run
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h7223));
      for (int i = 0; i < 32; i++) m[i] = 16'h0000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wb(1'b1, 8'h18, 32'hFFFF_FFFF);
      wb(1'b1, ble_pkg::ADR_EDGE, 32'hFFFF_FFFF);
      for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0000_0000);
      sel <= 4'h1;
      wb(1'b1, ble_pkg::ADR_OPER, 32'hFFFF_FFFF);
      sel <= 4'hF;
      rd(ble_pkg::ADR_OPER, 32'h0000_00FF);
      for (int w = 16; w < 18; w++) begin
         wb(1'b1, ble_pkg::ADR_MADR, 32'(w));
         wb(1'b1, ble_pkg::ADR_MDAT, 32'h0000_0000);
      end
      wb(1'b1, ble_pkg::ADR_FLAG, 32'h0000_00AA);
      flg = 8'hAA;
      for (int i = 0; i < 400; i++) begin
         logic [4:0] w;
         w = ws[$urandom_range(3)];
         popc = ops[$urandom_range(6)];
         if ((popc[11:8] == 4'h5 && w == 5'h00) || (popc[7:4] != 4'hF && w == 5'h1C)) w = 5'h01;
         ps = 1'($urandom_range(1));
         pr = 1'($urandom_range(1));
         pe = $urandom_range(3) != 0;
         pi = 1'($urandom_range(1));
         pn = 4'($urandom_range(3));
         run({10'h000, 6'($urandom_range(40)), 8'($urandom_range(17)), 3'h0, w});
         rdw(w);
         rdw(w + 5'h01);
      end
      rd(ble_pkg::ADR_FLAG, {24'h0, flg});
      rd(ble_pkg::ADR_EDGE, {16'h0, hist});
      {popc, ps, pe, pi} = {ble_pkg::OP_SET, 3'b111};
      run(32'h0000_0300);
      {popc, pi} = {ble_pkg::OP_CLR, 1'b0};
      run(32'h0000_0300);
      {popc, pe, pi} = {ble_pkg::OP_REFR, 2'b01};
      run(32'h0000_0000);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 32; i++) if (i < 16 || i > 23) m[i] = 16'h0000;
      rdw(5'h10);
      rdw(5'h01);
      rd(ble_pkg::ADR_EDGE, 32'h0000_0000);
      chk("terminals", 32'h0000_0000, {16'h0000, term});
      end_sim();
   end
endmodule : tb
